/* File: vcmu_clip_feed.sv */
// Model of the clip-data stream that bus-master reads deliver to the unit.
`timescale 1ns/1ps
`default_nettype none
module vcmu_clip_feed (
    input wire logic clk_sys,
    input wire logic fieldStart,
    input wire logic stall,
    input wire logic clipInReady,
    output logic clipInValid,
    output logic [31:0] clipInData
);
    logic [31:0] mem [0:63];
    logic [6:0] ptr_r = 7'h40;
    logic [31:0] last_r = 32'h0;
    initial clipInValid = 1'b0;
    // Idle data is the inverse of the last word, so a stale value never passes as fresh.
    assign clipInData = clipInValid ? mem[ptr_r[5:0]] : ~last_r;
    always @(posedge clk_sys) begin
        if (fieldStart) begin
            ptr_r <= 7'h00;
            clipInValid <= 1'b0;
        end else if (clipInValid && clipInReady) begin
            ptr_r <= ptr_r + 7'h01;
            last_r <= clipInData;
            clipInValid <= ptr_r < 7'h3F && !stall;
        end else if (!clipInValid) begin
            clipInValid <= ptr_r < 7'h40 && !stall;
        end
    end
endmodule // vcmu_clip_feed
`default_nettype wire

/* File: vcmu_clip_unit.v */
// Video clip mask unit: chroma key, bit mask and rectangle list clipping.
// What this block does
// - OR enabled, optionally inverted chroma and clip masks.
// - Clip words arrive through the input stream.
// - Sixteen rectangles in sixty-four word store.
// - Bit mask: one bit per pixel, MSB first.
// - Clip output stream, optional background merge.
// - Planar format disables clip streams entirely.
// - Interlace select; coordinates refer to target.
// - Rectangles are half open from origin zero.
// - Window suppresses when line and pixel bits zero.
// - Any window suppressing suppresses the pixel.
// - Display registers start in display state.
// - Line start loads matching line entry.
// - Pixel match loads column register, else hold.
// - Zero coordinate ends a list.
// - Full lists need no terminator.
// - Word: coordinate 26..16, display bits 15..0.
// - Pixel list even words, line list odd.
`timescale 1ns/1ps
`default_nettype none
`include "vcmu_consts.vh"
module vcmu_clip_unit #(
    parameter WINDOWS = 16,
    parameter CW = 11
) (
    input wire clk_sys,
    input wire resetn,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire fieldStart,
    input wire lineStart,
    input wire pixValid,
    input wire chromaKey,
    input wire clipInValid,
    input wire [31:0] clipInData,
    output reg clipInReady,
    output reg maskOut,
    output reg maskOutValid,
    output reg clipOutValid,
    output reg [31:0] clipOutData,
    input wire clipOutReady
);
    localparam ST_LOAD = 3'b001;
    localparam ST_RUN = 3'b010;
    localparam ST_IDLE = 3'b100;

    function [CW-1:0] coordOf;
        input [31:0] w;
        coordOf = w[`VCMU_COORD_HI:`VCMU_COORD_LO];
    endfunction
    function [WINDOWS-1:0] infoOf;
        input [31:0] w;
        infoOf = w[`VCMU_INFO_HI:`VCMU_INFO_LO];
    endfunction

    reg [`VCMU_CTRL_W-1:0] ctrl_r;
    reg [2:0] state_r;
    reg [5:0] loadAddr_r;
    reg [4:0] pixIdx_r;
    reg [4:0] lineIdx_r;
    reg pixDone_r;
    reg lineDone_r;
    reg [WINDOWS-1:0] colInfo_r;
    reg [WINDOWS-1:0] rowInfo_r;
    reg [CW-1:0] pixCnt_r;
    reg [CW-1:0] lineCnt_r;
    reg oddField_r;
    reg [31:0] outWord_r;
    reg [4:0] outCnt_r;
    reg stall_r;

    wire ckEn = ctrl_r[`VCMU_CTRL_CK_EN];
    wire ckInv = ctrl_r[`VCMU_CTRL_CK_INV];
    wire clipEn = ctrl_r[`VCMU_CTRL_CLIP_EN];
    wire clipInv = ctrl_r[`VCMU_CTRL_CLIP_INV];
    wire maskMode = ctrl_r[`VCMU_CTRL_MODE];
    wire outEn = ctrl_r[`VCMU_CTRL_OUT_EN];
    wire outBg = ctrl_r[`VCMU_CTRL_OUT_BG];
    wire outSel = ctrl_r[`VCMU_CTRL_OUT_SEL];
    wire interl = ctrl_r[`VCMU_CTRL_INTERL];
    wire planar = ctrl_r[`VCMU_CTRL_PLANAR];

    // Input synchronisers for the chroma key and pixel strobes are not needed:
    // they come from the scaler on this clock.
    wire apbAcc = psel && penable && !pready;
    wire [31:0] pixWord;
    wire [31:0] lineWord;
    wire storeWr = (state_r == ST_LOAD) && clipInValid && clipInReady && !maskMode;
    vcmu_word_store #(.DEPTH(`VCMU_STORE_WORDS), .AW(6)) uStore (
        .clk_sys(clk_sys),
        .ce(ce),
        .wrEn(storeWr),
        .wrAddr(loadAddr_r),
        .wrData(clipInData),
        .rdAddrA({pixIdx_r, 1'b0}),
        .rdAddrB({lineIdx_r, 1'b1}),
        .rdDataA(pixWord),
        .rdDataB(lineWord)
    );

    wire useStream = !planar;
    wire pixStep = pixValid && !stall_r;
    // The unpacker only takes a word that the registered ready has offered, so the
    // feed and the unpacker always agree on which words were consumed.
    wire mTake = clipInValid && clipInReady && maskMode && useStream;
    wire mbit;
    wire mvalid;
    wire mReady;
    vcmu_mask_shift uMask (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .restart(fieldStart),
        .pixStep(pixStep && maskMode && useStream),
        .wordValid(mTake),
        .wordData(clipInData),
        .wordReady(mReady),
        .maskBit(mbit),
        .maskValid(mvalid)
    );

    // Effective line number in the target window; in interlaced mode a field
    // carries every second target line.
    wire [CW-1:0] tgtLine = interl ? {lineCnt_r[CW-2:0], oddField_r} : lineCnt_r;
    wire pixCoordZero = coordOf(pixWord) == {CW{1'b0}};
    wire lineCoordZero = coordOf(lineWord) == {CW{1'b0}};
    wire pixHit = !pixDone_r && !pixCoordZero && (coordOf(pixWord) == pixCnt_r);
    wire lineHit = !lineDone_r && !lineCoordZero && (coordOf(lineWord) == tgtLine);

    // A window hides the pixel only when both its bits say no display.
    wire [WINDOWS-1:0] colNow = pixHit ? infoOf(pixWord) : colInfo_r;
    wire [WINDOWS-1:0] hideWin = ~(colNow | rowInfo_r);
    wire rectSup = |hideWin;
    wire clipRaw = maskMode ? (mvalid ? !mbit : 1'b0) : rectSup;
    wire clipTerm = clipEn && useStream && (clipRaw ^ clipInv);
    wire ckTerm = ckEn && (chromaKey ^ ckInv);
    wire suppress = ckTerm | clipTerm;
    wire outBit = outSel ? (outBg ? (clipRaw | !chromaKey) : clipRaw) : chromaKey;

    always @(posedge clk_sys) begin
        if (!resetn) begin
            ctrl_r <= `VCMU_CTRL_RST;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= apbAcc;
            pslverr <= 1'b0;
            if (apbAcc) begin
                prdata <= 32'h00000000;
                case (paddr)
                    `VCMU_ADDR_CTRL: begin
                        if (pwrite) begin
                            ctrl_r <= pwdata[`VCMU_CTRL_W-1:0];
                        end
                        prdata <= {22'h000000, ctrl_r};
                    end
                    `VCMU_ADDR_STATUS: begin
                        prdata <= {24'h000000, stall_r, lineDone_r, pixDone_r, 2'b00, state_r};
                    end
                    `VCMU_ADDR_LINE: begin
                        prdata <= {5'h00, pixCnt_r, 5'h00, lineCnt_r};
                    end
                    default: begin
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end else begin
            pready <= 1'b0;
        end
    end

    always @(posedge clk_sys) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            loadAddr_r <= 6'h00;
            clipInReady <= 1'b0;
            pixIdx_r <= 5'h00;
            lineIdx_r <= 5'h00;
            pixDone_r <= 1'b0;
            lineDone_r <= 1'b0;
            colInfo_r <= `VCMU_ALL_DISPLAY;
            rowInfo_r <= `VCMU_ALL_DISPLAY;
            pixCnt_r <= {CW{1'b0}};
            lineCnt_r <= {CW{1'b0}};
            oddField_r <= 1'b0;
            maskOut <= 1'b0;
            maskOutValid <= 1'b0;
            clipOutValid <= 1'b0;
            clipOutData <= 32'h00000000;
            outWord_r <= 32'h00000000;
            outCnt_r <= 5'h00;
            stall_r <= 1'b0;
        end else if (ce) begin
            maskOutValid <= pixStep;
            if (pixStep) begin
                maskOut <= suppress;
            end
            if (fieldStart) begin
                state_r <= (useStream && !maskMode) ? ST_LOAD : ST_RUN;
                loadAddr_r <= 6'h00;
                clipInReady <= useStream && !maskMode;
                pixIdx_r <= 5'h00;
                lineIdx_r <= 5'h00;
                pixDone_r <= 1'b0;
                lineDone_r <= 1'b0;
                colInfo_r <= `VCMU_ALL_DISPLAY;
                rowInfo_r <= `VCMU_ALL_DISPLAY;
                pixCnt_r <= {CW{1'b0}};
                lineCnt_r <= {CW{1'b0}};
                oddField_r <= !oddField_r;
                outCnt_r <= 5'h00;
            end else begin
                case (state_r)
                    ST_LOAD: begin
                        if (storeWr) begin
                            loadAddr_r <= loadAddr_r + 6'h01;
                            if (loadAddr_r == 6'h3F) begin
                                state_r <= ST_RUN;
                                clipInReady <= 1'b0;
                            end
                        end
                    end
                    ST_RUN: begin
                        clipInReady <= maskMode && useStream && mReady && !mTake;
                        if (lineStart) begin
                            pixCnt_r <= {CW{1'b0}};
                            lineCnt_r <= lineCnt_r + {{(CW-1){1'b0}}, 1'b1};
                            pixIdx_r <= 5'h00;
                            pixDone_r <= 1'b0;
                            colInfo_r <= `VCMU_ALL_DISPLAY;
                            if (lineHit) begin
                                rowInfo_r <= infoOf(lineWord);
                                lineDone_r <= (lineIdx_r == 5'h1F);
                                lineIdx_r <= lineIdx_r + 5'h01;
                            end else if (!lineDone_r && lineCoordZero && lineIdx_r != 5'h00) begin
                                lineDone_r <= 1'b1;
                            end
                        end else if (pixStep) begin
                            pixCnt_r <= pixCnt_r + {{(CW-1){1'b0}}, 1'b1};
                            if (pixHit) begin
                                colInfo_r <= infoOf(pixWord);
                                pixDone_r <= (pixIdx_r == 5'h1F);
                                pixIdx_r <= pixIdx_r + 5'h01;
                            end else if (!pixDone_r && pixCoordZero && pixIdx_r != 5'h00) begin
                                pixDone_r <= 1'b1;
                            end
                        end
                    end
                    ST_IDLE: begin
                        clipInReady <= 1'b0;
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
            // Output packing stalls the pixel path rather than drop mask bits.
            if (clipOutValid && clipOutReady) begin
                clipOutValid <= 1'b0;
            end
            if (pixStep && outEn && useStream) begin
                outWord_r <= {outWord_r[30:0], outBit};
                outCnt_r <= outCnt_r + 5'h01;
                if (outCnt_r == 5'h1F) begin
                    clipOutData <= {outWord_r[30:0], outBit};
                    clipOutValid <= 1'b1;
                end
            end
            stall_r <= clipOutValid && !clipOutReady;
        end
    end
endmodule // vcmu_clip_unit
`default_nettype wire

/* File: vcmu_clip_unit_assertions.sv */
// Port-level assertion checker for the video clip mask unit.
`timescale 1ns/1ps
`default_nettype none
module vcmu_clip_unit_assertions (
    input wire clk_sys,
    input wire resetn,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire pixValid,
    input wire chromaKey,
    input wire maskOut,
    input wire maskOutValid,
    input wire clipInReady,
    input wire clipOutValid
);
    logic [9:0] ctrl_r;
    // Shadow of the control word, so mode-dependent checks know what software chose.
    always @(posedge clk_sys) begin
        if (!resetn) begin
            ctrl_r <= 10'h000;
        end else if (psel && penable && pready && pwrite && paddr == 12'h000) begin
            ctrl_r <= pwdata[9:0];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    apb_wait_a: assert property (ce && psel && penable && !pready |=> pready)
        else $error("access not answered one cycle later");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    unmapped_err_a: assert property (psel && penable && pready
        && !(paddr inside {12'h000, 12'h004, 12'h008}) |-> pslverr)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (pready && (paddr inside {12'h000, 12'h004, 12'h008})
        |-> !pslverr) else $error("mapped access refused");
    mask_cause_a: assert property (maskOutValid |-> $past(pixValid) || $past(pixValid, 2))
        else $error("mask result without a pixel");
    key_mask_a: assert property (maskOutValid && (ctrl_r == 10'h001 || ctrl_r == 10'h003)
        |-> maskOut == ($past(chromaKey) ^ ctrl_r[1])) else $error("key mask wrong");
    planar_in_a: assert property (ctrl_r[9] && $past(ctrl_r[9]) |-> !clipInReady)
        else $error("clip input used in planar format");
    planar_out_a: assert property (ctrl_r[9] && $past(ctrl_r[9]) |-> !clipOutValid)
        else $error("clip output written in planar format");
endmodule // vcmu_clip_unit_assertions
bind vcmu_clip_unit vcmu_clip_unit_assertions chk (.clk_sys(clk_sys), .resetn(resetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .pixValid(pixValid), .chromaKey(chromaKey),
    .maskOut(maskOut), .maskOutValid(maskOutValid), .clipInReady(clipInReady),
    .clipOutValid(clipOutValid));
`default_nettype wire

/* File: vcmu_clip_unit_tb.sv */
// Self-checking testbench for the video clip mask unit.
`timescale 1ns/1ps
`default_nettype none
module vcmu_clip_unit_tb;
    logic clk_sys, resetn, psel, penable, pwrite, fieldStart, lineStart, pixValid, chromaKey;
    logic stall, pready, pslverr, clipInReady, maskOut, maskOutValid, clipOutValid;
    logic clipInValid, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, clipInData, clipOutData, rnd, rd, outExp;
    int errors, checked;
    vcmu_clip_unit dut (.clk_sys(clk_sys), .resetn(resetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fieldStart(fieldStart), .lineStart(lineStart),
        .pixValid(pixValid), .chromaKey(chromaKey), .clipInValid(clipInValid),
        .clipInData(clipInData), .clipInReady(clipInReady), .maskOut(maskOut),
        .maskOutValid(maskOutValid), .clipOutValid(clipOutValid), .clipOutData(clipOutData),
        .clipOutReady(!stall));
    vcmu_clip_feed feed (.clk_sys(clk_sys), .fieldStart(fieldStart), .stall(stall),
        .clipInReady(clipInReady), .clipInValid(clipInValid), .clipInData(clipInData));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [31:0] ent(input int c, input logic [15:0] info);
        return {5'h00, c[10:0], info};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (!pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic mark(input logic f);
        @(posedge clk_sys);
        fieldStart <= f;
        lineStart <= !f;
        @(posedge clk_sys);
        fieldStart <= 1'b0;
        lineStart <= 1'b0;
    endtask
    task automatic pix(input logic ck, input logic exp);
        int n;
        n = 0;
        @(posedge clk_sys);
        pixValid <= 1'b1;
        chromaKey <= ck;
        @(posedge clk_sys);
        pixValid <= 1'b0;
        do @(posedge clk_sys); while (!maskOutValid && ++n < 4);
        chk(32'(maskOutValid), 32'h1);
        chk(32'(maskOut), 32'(exp));
    endtask
    initial begin
        int n;
        {psel, penable, pwrite, fieldStart, lineStart, pixValid, chromaKey, stall} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        resetn = 1'b0;
        rnd = 32'h73CCD9D5;
        for (int i = 0; i < 64; i++) feed.mem[i] = 32'h0;
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h000, 32'h3FF);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h3FF);
        apb(1'b0, 12'h0FC, 32'h0);
        chk(32'(err), 32'h1);
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, 12'h000, m ? 32'h3 : 32'h1);
            mark(1'b1);
            mark(1'b0);
            repeat (16) begin
                rnd = lfsr(rnd);
                pix(rnd[0], rnd[0] ^ m[0]);
            end
        end
        // One window covering pixels 5..8 of lines 1..2; zero entries end both lists.
        feed.mem[0] = ent(5, 16'hFFFE);
        feed.mem[2] = ent(9, 16'hFFFF);
        feed.mem[1] = ent(1, 16'hFFFE);
        feed.mem[3] = ent(3, 16'hFFFF);
        apb(1'b1, 12'h000, 32'h005);
        mark(1'b1);
        n = 0;
        while (feed.ptr_r != 7'h40 && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
        chk(32'(feed.ptr_r), 32'd64);
        for (int l = 0; l < 4; l++) begin
            mark(1'b0);
            for (int p = 0; p < 11; p++) begin
                rnd = lfsr(rnd);
                pix(rnd[0], rnd[0] | (l inside {[1:2]} && p inside {[5:8]}));
            end
        end
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h000B0004);
        // Background mask out on line 0, where no rectangle applies: the word is the inverted key.
        apb(1'b1, 12'h000, 32'h0E1);
        mark(1'b1);
        mark(1'b0);
        for (int p = 0; p < 32; p++) begin
            rnd = lfsr(rnd);
            outExp = {outExp[30:0], !rnd[0]};
            pix(rnd[0], rnd[0]);
        end
        chk(32'(clipOutValid), 32'h1);
        chk(clipOutData, outExp);
        feed.mem[0] = lfsr(rnd);
        feed.mem[1] = lfsr(feed.mem[0]);
        apb(1'b1, 12'h000, 32'h014);
        mark(1'b1);
        mark(1'b0);
        for (int p = 0; p < 40; p++) begin
            rnd = lfsr(rnd);
            stall <= p < 16 && rnd[3];
            pix(1'b0, !feed.mem[p / 32][31 - p % 32]);
        end
        stall <= 1'b0;
        apb(1'b1, 12'h000, 32'h205);
        mark(1'b1);
        mark(1'b0);
        repeat (8) begin
            rnd = lfsr(rnd);
            pix(rnd[0], rnd[0]);
        end
        chk(32'(clipInReady), 32'h0);
        final_report();
    end
    initial begin
        repeat (40000) @(posedge clk_sys);
        errors++;
        final_report();
    end
endmodule // vcmu_clip_unit_tb
`default_nettype wire

/* File: vcmu_consts.vh */
// Constants for the video clip mask unit.
`ifndef VCMU_CONSTS_VH
`define VCMU_CONSTS_VH
`define VCMU_ADDR_CTRL 12'h000
`define VCMU_ADDR_STATUS 12'h004
`define VCMU_ADDR_LINE 12'h008
`define VCMU_CTRL_CK_EN 0
`define VCMU_CTRL_CK_INV 1
`define VCMU_CTRL_CLIP_EN 2
`define VCMU_CTRL_CLIP_INV 3
`define VCMU_CTRL_MODE 4
`define VCMU_CTRL_OUT_EN 5
`define VCMU_CTRL_OUT_BG 6
`define VCMU_CTRL_OUT_SEL 7
`define VCMU_CTRL_INTERL 8
`define VCMU_CTRL_PLANAR 9
`define VCMU_CTRL_W 10
`define VCMU_CTRL_RST 10'h000
`define VCMU_COORD_HI 26
`define VCMU_COORD_LO 16
`define VCMU_INFO_HI 15
`define VCMU_INFO_LO 0
`define VCMU_STORE_WORDS 64
`define VCMU_ALL_DISPLAY 16'hFFFF
`define VCMU_WORD_MSB 31
`endif

/* File: vcmu_mask_shift.v */
// Bit mask unpacker: one word covers 32 pixels, first pixel in the top bit.
`timescale 1ns/1ps
`default_nettype none
`include "vcmu_consts.vh"
module vcmu_mask_shift (
    input wire clk_sys,
    input wire resetn,
    input wire ce,
    input wire restart,
    input wire pixStep,
    input wire wordValid,
    input wire [31:0] wordData,
    output wire wordReady,
    output wire maskBit,
    output wire maskValid
);
    reg [31:0] shift_r;
    reg [5:0] left_r;
    wire empty = (left_r == 6'h00);
    wire take = wordValid && (empty || (pixStep && left_r == 6'h01));
    assign wordReady = empty || (pixStep && left_r == 6'h01);
    assign maskBit = shift_r[`VCMU_WORD_MSB];
    assign maskValid = !empty;
    always @(posedge clk_sys) begin
        if (!resetn || (ce && restart)) begin
            shift_r <= 32'h00000000;
            left_r <= 6'h00;
        end else if (ce) begin
            if (take) begin
                shift_r <= wordData;
                left_r <= 6'h20;
            end else if (pixStep && !empty) begin
                shift_r <= {shift_r[30:0], 1'b0};
                left_r <= left_r - 6'h01;
            end
        end
    end
endmodule // vcmu_mask_shift
`default_nettype wire

/* File: vcmu_word_store.v */
// Clip word store for the rectangle lists, filled from the clip-data input stream.
`timescale 1ns/1ps
`default_nettype none
`include "vcmu_consts.vh"
module vcmu_word_store #(
    parameter DEPTH = `VCMU_STORE_WORDS,
    parameter AW = 6
) (
    input wire clk_sys,
    input wire ce,
    input wire wrEn,
    input wire [AW-1:0] wrAddr,
    input wire [31:0] wrData,
    input wire [AW-1:0] rdAddrA,
    input wire [AW-1:0] rdAddrB,
    output wire [31:0] rdDataA,
    output wire [31:0] rdDataB
);
    reg [31:0] mem [0:DEPTH-1];
    always @(posedge clk_sys) begin
        if (ce && wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end
    assign rdDataA = mem[rdAddrA];
    assign rdDataB = mem[rdAddrB];
endmodule // vcmu_word_store
`default_nettype wire
